//--- hw/bts_cfg.svh
`ifndef BTS_CFG_SVH
`define BTS_CFG_SVH

// instruction word layout
`define BTS_WORD_W     12
`define BTS_OPC_MSB    11
`define BTS_OPC_LSB    8
`define BTS_BIT_MSB    7
`define BTS_BIT_LSB    5
`define BTS_FADR_MSB   4
`define BTS_FADR_LSB   0

// opcodes of the two bit tests
`define BTS_OPC_CLR    4'h6
`define BTS_OPC_SET    4'h7

// no-operation word substituted for a dropped prefetch
`define BTS_NOP_WORD   12'h000

`endif

//--- hw/bts_dec_if.sv
`timescale 1ns/1ps

interface bts_dec_if;
   import bts_pkg::*;

   bts_word_t  word;
   logic       is_clr;
   logic       is_set;
   bts_bit_t   bit_sel;
   bts_faddr_t faddr;

   modport dec (
      input  word,
      output is_clr,
      output is_set,
      output bit_sel,
      output faddr
   );

   modport usr (
      output word,
      input  is_clr,
      input  is_set,
      input  bit_sel,
      input  faddr
   );
endinterface

//--- hw/bts_decode.sv
`timescale 1ns/1ps
`include "bts_cfg.svh"

module bts_decode (
   // decoded instruction
   bts_dec_if.dec dec
);
   import bts_pkg::*;

   always_comb begin
      dec.is_clr  = (bts_opcode(dec.word) == `BTS_OPC_CLR);
      dec.is_set  = (bts_opcode(dec.word) == `BTS_OPC_SET);
      dec.bit_sel = dec.word[`BTS_BIT_MSB:`BTS_BIT_LSB];
      dec.faddr   = dec.word[`BTS_FADR_MSB:`BTS_FADR_LSB];
   end

endmodule

//--- hw/bts_exec.sv
`timescale 1ns/1ps
`include "bts_cfg.svh"

module bts_exec (
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rstn,
   // fetch side: prefetched word offered to execute
   input  wire bts_pkg::bts_word_t fetch_word,
   input  wire logic               fetch_valid,
   // file register read port
   output bts_pkg::bts_faddr_t     rf_addr,
   input  wire logic [7:0]         rf_rdata,
   // execute stage
   output bts_pkg::bts_word_t      exec_word,
   output logic                    exec_valid,
   output logic                    exec_squashed,
   output logic                    bit_test_active,
   output logic                    skip_taken,
   output logic                    flag_write_block
);
   import bts_pkg::*;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////////////
   // decode of the executing word

   bts_dec_if dif ();

   bts_decode u_decode (
      .dec (dif.dec)
   );

   bts_word_t  exec_word_r;
   bts_word_t  exec_word_nxt;
   logic       exec_valid_r;
   logic       exec_valid_nxt;
   logic       exec_squashed_r;
   logic       exec_squashed_nxt;
   bts_state_e state_r;
   bts_state_e state_nxt;
   logic       tested_bit;
   logic       take_skip;

   assign dif.word = exec_word_r;

   ////////////////////////////////////////////////////////////////////////////
   // test of the selected bit

   // the file read is combinational so the test resolves in the execute cycle
   always_comb begin
      tested_bit = rf_rdata[dif.bit_sel];
      take_skip  = 1'b0;
      if (exec_valid_r) begin
         if (dif.is_clr && !tested_bit) begin
            take_skip = 1'b1;
         end
         if (dif.is_set && tested_bit) begin
            take_skip = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // execute stage and squash state

   // a skip taken while no prefetch is offered waits in ST_SQUASH, so the
   // next word that arrives is still the one dropped
   always_comb begin
      state_nxt         = state_r;
      exec_word_nxt     = exec_word_r;
      exec_valid_nxt    = 1'b0;
      exec_squashed_nxt = 1'b0;
      unique case (state_r)
         ST_RUN: begin
            if (fetch_valid) begin
               exec_valid_nxt = 1'b1;
               if (take_skip) begin
                  exec_word_nxt     = `BTS_NOP_WORD;
                  exec_squashed_nxt = 1'b1;
               end else begin
                  exec_word_nxt = fetch_word;
               end
            end else if (take_skip) begin
               state_nxt = ST_SQUASH;
            end
         end
         ST_SQUASH: begin
            if (fetch_valid) begin
               exec_valid_nxt    = 1'b1;
               exec_word_nxt     = `BTS_NOP_WORD;
               exec_squashed_nxt = 1'b1;
               state_nxt         = ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_r         <= ST_RUN;
         exec_word_r     <= `BTS_NOP_WORD;
         exec_valid_r    <= 1'b0;
         exec_squashed_r <= 1'b0;
      end else begin
         state_r         <= state_nxt;
         exec_word_r     <= exec_word_nxt;
         exec_valid_r    <= exec_valid_nxt;
         exec_squashed_r <= exec_squashed_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // the test only reads the file: no write strobe or flag update may follow
   assign rf_addr          = dif.faddr;
   assign exec_word        = exec_word_r;
   assign exec_valid       = exec_valid_r;
   assign exec_squashed    = exec_squashed_r;
   assign bit_test_active  = exec_valid_r && (dif.is_clr || dif.is_set);
   assign flag_write_block = bit_test_active;
   assign skip_taken       = take_skip;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   // encodings are restated here so a wrong field macro cannot hide
   // behind the decoder that uses the same macro
   sequence s_clr_hit;
      exec_valid && exec_word[11:8] == 4'h6 && rf_rdata[exec_word[7:5]] == 1'b0;
   endsequence

   sequence s_set_hit;
      exec_valid && exec_word[11:8] == 4'h7 && rf_rdata[exec_word[7:5]] == 1'b1;
   endsequence

   sequence s_nop_out;
      exec_valid && exec_squashed && exec_word == 12'h000;
   endsequence

   a_clr_decode_addr: assert property (
      exec_valid && exec_word[11:8] == 4'h6
      |-> bit_test_active && rf_addr == exec_word[4:0])
      else $error("skip-if-clear not decoded");

   a_clr_skip_nop: assert property (
      s_clr_hit ##0 (fetch_valid && state_r == ST_RUN) |=> s_nop_out)
      else $error("clear test hit did not drop prefetch");

   a_clr_miss_pass: assert property (
      exec_valid && exec_word[11:8] == 4'h6 && rf_rdata[exec_word[7:5]] && fetch_valid
      && state_r == ST_RUN
      |=> exec_valid && !exec_squashed && exec_word == $past(fetch_word))
      else $error("clear test miss altered next word");

   a_set_decode_addr: assert property (
      exec_valid && exec_word[11:8] == 4'h7
      |-> bit_test_active && rf_addr == exec_word[4:0])
      else $error("skip-if-set not decoded");

   a_set_skip_nop: assert property (
      s_set_hit ##0 (fetch_valid && state_r == ST_RUN) |=> s_nop_out)
      else $error("set test hit did not drop prefetch");

   a_set_miss_pass: assert property (
      exec_valid && exec_word[11:8] == 4'h7 && !rf_rdata[exec_word[7:5]] && fetch_valid
      && state_r == ST_RUN
      |=> exec_valid && !exec_squashed && exec_word == $past(fetch_word))
      else $error("set test miss altered next word");

   a_squash_cause: assert property (
      $rose(exec_squashed) |-> $past(skip_taken) || $past(state_r) == ST_SQUASH)
      else $error("no-op inserted without a taken skip");

   a_pending_skip: assert property (
      skip_taken && !fetch_valid ##1 fetch_valid[*1] |=> s_nop_out)
      else $error("deferred skip lost");

   a_test_no_write: assert property (
      flag_write_block == (exec_valid && exec_word[11:9] == 3'b011))
      else $error("flag write block does not follow a valid bit test");

   a_nontest_quiet: assert property (
      exec_valid && exec_word[11:9] != 3'b011
      |-> !bit_test_active && !flag_write_block && !skip_taken)
      else $error("non-test word treated as a bit test");

   a_skip_clr_cond: assert property (
      exec_valid && exec_word[11:8] == 4'h6
      |-> skip_taken == !rf_rdata[exec_word[7:5]])
      else $error("clear test skip decision wrong");

   a_skip_set_cond: assert property (
      exec_valid && exec_word[11:8] == 4'h7
      |-> skip_taken == rf_rdata[exec_word[7:5]])
      else $error("set test skip decision wrong");

   a_squash_single: assert property (
      exec_squashed
      |=> !exec_squashed)
      else $error("more than one word dropped for one skip");

   a_nop_quiet: assert property (
      s_nop_out
      |-> !bit_test_active && !skip_taken)
      else $error("substituted no-op acted as a test");

   sequence s_skip_idle;
      skip_taken && !fetch_valid;
   endsequence

   a_pending_hold: assert property (
      s_skip_idle ##1 !fetch_valid ##1 fetch_valid
      |=> s_nop_out)
      else $error("skip pending over two bubbles lost");

endmodule

//--- hw/bts_pkg.sv
`include "bts_cfg.svh"

package bts_pkg;

   typedef logic [`BTS_WORD_W-1:0]                 bts_word_t;
   typedef logic [`BTS_BIT_MSB-`BTS_BIT_LSB:0]     bts_bit_t;
   typedef logic [`BTS_FADR_MSB-`BTS_FADR_LSB:0]   bts_faddr_t;
   typedef logic [`BTS_OPC_MSB-`BTS_OPC_LSB:0]     bts_opc_t;

   typedef enum logic {
      ST_RUN,
      ST_SQUASH
   } bts_state_e;

   function automatic bts_opc_t bts_opcode(input bts_word_t w);
      return w[`BTS_OPC_MSB:`BTS_OPC_LSB];
   endfunction

endpackage

//--- sim/bit_test_skip_exec_test.sv
`timescale 1ns/1ps

module bit_test_skip_exec_test;
   import bts_pkg::*;
   logic       clk_sys     = 1'b0;
   logic       rstn        = 1'b0;
   bts_word_t  fetch_word  = 12'h000;
   logic       fetch_valid = 1'b0;
   bts_faddr_t rf_addr;
   logic [7:0] rf_rdata;
   bts_word_t  exec_word;
   logic       exec_valid;
   logic       exec_squashed;
   logic       bit_test_active;
   logic       skip_taken;
   logic       flag_write_block;
   int         error_cnt   = 0;
   int         n_checks    = 0;

   bts_exec dut (.clk_sys(clk_sys), .rstn(rstn), .fetch_word(fetch_word),
      .fetch_valid(fetch_valid), .rf_addr(rf_addr), .rf_rdata(rf_rdata),
      .exec_word(exec_word), .exec_valid(exec_valid), .exec_squashed(exec_squashed),
      .bit_test_active(bit_test_active), .skip_taken(skip_taken),
      .flag_write_block(flag_write_block));
   bts_rf_model u_rf (.rf_addr(rf_addr), .rf_rdata(rf_rdata));

   always #25 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic put(input bts_word_t w, input logic v);
      @(posedge clk_sys);
      fetch_word  <= w;
      fetch_valid <= v;
   endtask

   function automatic logic [7:0] rdat(input logic [4:0] a);
      return {a[2:0], a};
   endfunction

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      repeat (10) @(negedge clk_sys);
      chk("rst exec_valid", 12'(exec_valid), 12'h000);
      chk("rst exec_word", exec_word, 12'h000);
      chk("rst squashed", 12'(exec_squashed), 12'h000);
      chk("rst rf_addr", 12'(rf_addr), 12'h000);
      chk("rst skip", 12'(skip_taken), 12'h000);
      chk("rst active", 12'(bit_test_active), 12'h000);
      chk("rst block", 12'(flag_write_block), 12'h000);
   endtask

   // every file address under both tests; the follower is a non-test word
   task automatic t_bit_tests();
      logic [3:0] opc;
      logic [2:0] b;
      logic       sk;
      logic [7:0] d;
      bts_word_t  f;
      for (int o = 6; o <= 7; o++) begin
         for (int a = 0; a < 32; a++) begin
            opc = o[3:0];
            b   = 3'(a * 3);
            f   = 12'hA00 | 12'(a);
            d   = rdat(5'(a));
            sk  = (o == 7) ? d[b] : !d[b];
            put({opc, b, 5'(a)}, 1'b1);
            put(f, 1'b1);
            @(negedge clk_sys);
            chk("active", 12'(bit_test_active), 12'h001);
            chk("rf_addr", 12'(rf_addr), 12'(a));
            chk("skip", 12'(skip_taken), 12'(sk));
            chk("block", 12'(flag_write_block), 12'h001);
            put(12'h000, 1'b0);
            @(negedge clk_sys);
            chk("next word", exec_word, sk ? 12'h000 : f);
            chk("squashed", 12'(exec_squashed), 12'(sk));
            chk("next valid", 12'(exec_valid), 12'h001);
            chk("next active", 12'(bit_test_active), 12'h000);
            chk("next block", 12'(flag_write_block), 12'h000);
         end
      end
   endtask

   // a pending skip survives fetch bubbles and eats the next valid word only
   task automatic t_bubble();
      put(12'h600, 1'b1);
      put(12'h000, 1'b0);
      @(negedge clk_sys);
      chk("bub skip", 12'(skip_taken), 12'h001);
      put(12'h000, 1'b0);
      put(12'h7E1, 1'b1);
      put(12'h3C5, 1'b1);
      @(negedge clk_sys);
      chk("bub drop", exec_word, 12'h000);
      chk("bub squashed", 12'(exec_squashed), 12'h001);
      chk("bub dropped test", 12'(skip_taken), 12'h000);
      put(12'h000, 1'b0);
      @(negedge clk_sys);
      chk("bub after", exec_word, 12'h3C5);
      chk("bub after sq", 12'(exec_squashed), 12'h000);
   endtask

   // a set-test skip with a single bubble before the word that it drops
   task automatic t_bubble_one();
      put(12'h7A1, 1'b1);
      put(12'h000, 1'b0);
      @(negedge clk_sys);
      chk("one skip", 12'(skip_taken), 12'h001);
      put(12'h2C4, 1'b1);
      put(12'h1A5, 1'b1);
      @(negedge clk_sys);
      chk("one drop", exec_word, 12'h000);
      chk("one squashed", 12'(exec_squashed), 12'h001);
      put(12'h000, 1'b0);
      @(negedge clk_sys);
      chk("one after", exec_word, 12'h1A5);
      chk("one after sq", 12'(exec_squashed), 12'h000);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // the full sequence needs well under 400 cycles
   initial begin
      #(50 * 5000);
      error_cnt++;
      final_report();
   end

   initial begin
      t_reset();
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      t_bit_tests();
      t_bubble();
      t_bubble_one();
      final_report();
   end
endmodule

//--- sim/bts_rf_model.sv
`timescale 1ns/1ps

module bts_rf_model (
   // file register read port
   input  wire bts_pkg::bts_faddr_t rf_addr,
   output logic [7:0]               rf_rdata
);
   import bts_pkg::*;
   // contents follow the address so every tested bit is predictable
   // answer is combinational in the same cycle, as the core's file does
   assign rf_rdata = {rf_addr[2:0], rf_addr};
endmodule
